// file: design/light_sensor_command_control.sv
// Command decode and power/conversion control of the light sensor
// Contract
// - Normal command low five bits select register
// - Transaction type 11 makes index special code
// - Code 00001 clears interrupt flag and output
// - Code 00010 stops manual integration
// - Code 00011 starts manual integration
// - Manual duration readable in timer registers
// - Control register resets to zero
// - Bit five reads interrupt, ignores writes
// - Bit four set after integration completes
// - Bit one enables both converters
// - Bit zero powers device on or off
// - Convert only when power and enable set
// - Type 00 repeats, 01 auto-increments index
// - Zero integration cycles selects manual timing
`timescale 1ns/1ps
module light_sensor_command_control
   import light_sensor_pkg::*;
#(
   parameter int TICK_CYCLES = TIMER_TICK_CYCLES
) (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic clk_en_in,
   input wire logic wr_valid_in,
   input wire logic wr_is_command_in,
   input wire logic [7:0] wr_data_in,
   input wire logic rd_strobe_in,
   input wire logic [7:0] ext_read_data_in,
   input wire logic [7:0] integration_cycles_in,
   input wire logic adc_cycle_done_in,
   input wire logic interrupt_set_in,
   output logic [7:0] read_data_out,
   output logic [4:0] register_index_out,
   output logic reg_write_out,
   output logic [4:0] reg_write_index_out,
   output logic [7:0] reg_write_data_out,
   output logic power_out,
   output logic adc_enable_out,
   output logic converting_out,
   output logic manual_start_out,
   output logic manual_stop_out,
   output logic manual_active_out,
   output logic interrupt_out
);
   // ***********************************************
   // Decode
   // ***********************************************
   function automatic logic is_special(input logic [7:0] cmd, input logic [4:0] code);
      is_special = (cmd[CMD_TYPE_MSB:CMD_TYPE_LSB] == TYPE_SPECIAL) && (cmd[INDEX_MSB:0] == code);
   endfunction

   logic [1:0] cmd_type;
   logic [4:0] reg_index;
   logic power;
   logic adc_enable;
   logic adc_valid;
   logic interrupt_flag;
   logic [TIMER_W-1:0] duration;

   logic cmd_write;
   logic data_write;
   logic manual_mode;
   logic clear_cmd;
   logic start_cmd;
   logic stop_cmd;
   logic ctrl_write;
   logic advance;

   assign cmd_write = wr_valid_in && wr_is_command_in;
   assign data_write = wr_valid_in && !wr_is_command_in;
   assign manual_mode = (integration_cycles_in == MANUAL_TIMING);
   assign clear_cmd = cmd_write && is_special(wr_data_in, SF_INT_CLEAR);
   assign start_cmd = cmd_write && is_special(wr_data_in, SF_START) && manual_mode && converting_out;
   assign stop_cmd = cmd_write && is_special(wr_data_in, SF_STOP) && manual_mode && manual_active_out;
   assign ctrl_write = data_write && (reg_index == CTRL_ADDR);
   assign advance = (data_write || rd_strobe_in) && (cmd_type == TYPE_AUTO);

   // ***********************************************
   // Register pointer
   // ***********************************************
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cmd_type <= TYPE_RESET;
         reg_index <= INDEX_RESET;
      end else if (clk_en_in) begin
         if (cmd_write) begin
            cmd_type <= wr_data_in[CMD_TYPE_MSB:CMD_TYPE_LSB];
            // Special codes leave the pointer alone
            if (wr_data_in[CMD_TYPE_MSB:CMD_TYPE_LSB] != TYPE_SPECIAL) begin
               reg_index <= wr_data_in[INDEX_MSB:0];
            end
         end else if (advance) begin
            reg_index <= reg_index + INDEX_STEP;
         end
      end
   end

   // ***********************************************
   // Control register
   // ***********************************************
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         power <= CTRL_RESET[POWER_BIT];
         adc_enable <= CTRL_RESET[ENABLE_BIT];
      end else if (clk_en_in && ctrl_write) begin
         power <= wr_data_in[POWER_BIT];
         adc_enable <= wr_data_in[ENABLE_BIT];
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         interrupt_flag <= CTRL_RESET[INTR_BIT];
      end else if (clk_en_in) begin
         // Set wins over a simultaneous clear
         if (interrupt_set_in) begin
            interrupt_flag <= 1'b1;
         end else if (clear_cmd) begin
            interrupt_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         adc_valid <= CTRL_RESET[VALID_BIT];
      end else if (clk_en_in) begin
         if ((adc_cycle_done_in && converting_out) || manual_stop_out) begin
            adc_valid <= 1'b1;
         end else if (!power) begin
            adc_valid <= 1'b0;
         end
      end
   end

   // ***********************************************
   // Conversion and manual integration
   // ***********************************************
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         converting_out <= 1'b0;
         manual_start_out <= 1'b0;
         manual_stop_out <= 1'b0;
         manual_active_out <= 1'b0;
      end else if (clk_en_in) begin
         converting_out <= power && adc_enable;
         manual_start_out <= start_cmd;
         manual_stop_out <= stop_cmd;
         if (!power || !adc_enable) begin
            manual_active_out <= 1'b0;
         end else if (start_cmd) begin
            manual_active_out <= 1'b1;
         end else if (stop_cmd) begin
            manual_active_out <= 1'b0;
         end
      end
   end

   manual_integration_timer #(
      .TICK_CYCLES(TICK_CYCLES),
      .WIDTH(TIMER_W)
   ) timer_inst (
      .core_clk_in(core_clk_in),
      .resetn_in(resetn_in),
      .clk_en_in(clk_en_in),
      .start_in(manual_start_out),
      .stop_in(manual_stop_out),
      .halt_in(!converting_out),
      .duration_out(duration)
   );

   // ***********************************************
   // Read data and write forwarding
   // ***********************************************
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         read_data_out <= BYTE_ZERO;
      end else if (clk_en_in) begin
         unique case (reg_index)
            CTRL_ADDR: begin
               read_data_out <= BYTE_ZERO;
               read_data_out[POWER_BIT] <= power;
               read_data_out[ENABLE_BIT] <= adc_enable;
               read_data_out[VALID_BIT] <= adc_valid;
               read_data_out[INTR_BIT] <= interrupt_flag;
            end
            TIMER_LO_ADDR: begin
               read_data_out <= duration[7:0];
            end
            TIMER_HI_ADDR: begin
               read_data_out <= duration[15:8];
            end
            default: begin
               read_data_out <= ext_read_data_in;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         reg_write_out <= 1'b0;
         reg_write_index_out <= INDEX_RESET;
         reg_write_data_out <= BYTE_ZERO;
      end else if (clk_en_in) begin
         reg_write_out <= data_write && !ctrl_write;
         reg_write_index_out <= reg_index;
         reg_write_data_out <= wr_data_in;
      end
   end

   assign register_index_out = reg_index;
   assign power_out = power;
   assign adc_enable_out = adc_enable;
   assign interrupt_out = interrupt_flag;

   // ***********************************************
   // Checks
   // ***********************************************
   default clocking cb @(posedge core_clk_in);
   endclocking
   default disable iff (!resetn_in);

   index_load_a: assert property (
      clk_en_in && cmd_write && wr_data_in[CMD_TYPE_MSB:CMD_TYPE_LSB] != TYPE_SPECIAL
      |=> reg_index == $past(wr_data_in[INDEX_MSB:0])) else $error("pointer not loaded");
   special_keep_a: assert property (
      clk_en_in && cmd_write && wr_data_in[CMD_TYPE_MSB:CMD_TYPE_LSB] == TYPE_SPECIAL
      |=> $stable(reg_index)) else $error("special code moved pointer");
   // Read data lags the flag by one edge
   intr_clear_a: assert property (
      clk_en_in && clear_cmd && !interrupt_set_in
      |=> !interrupt_out ##1 (!read_data_out[INTR_BIT] || !$past(clk_en_in) || $past(reg_index) != CTRL_ADDR))
      else $error("interrupt not cleared");
   stop_gate_a: assert property (
      manual_stop_out |-> $past(integration_cycles_in) == MANUAL_TIMING)
      else $error("stop outside manual mode");
   start_gate_a: assert property (
      clk_en_in && start_cmd |=> manual_start_out ##1 (!clk_en_in || manual_active_out))
      else $error("manual start lost");
   intr_read_a: assert property (
      clk_en_in && reg_index == CTRL_ADDR |=> read_data_out[INTR_BIT] == $past(interrupt_flag))
      else $error("interrupt bit misread");
   power_write_a: assert property (
      clk_en_in && ctrl_write |=> power_out == $past(wr_data_in[POWER_BIT])
      && adc_enable_out == $past(wr_data_in[ENABLE_BIT])) else $error("control write lost");
   convert_gate_a: assert property (
      clk_en_in |=> converting_out == $past(power && adc_enable))
      else $error("conversion gating wrong");
   auto_inc_a: assert property (
      clk_en_in && !cmd_write && advance |=> reg_index == $past(reg_index) + INDEX_STEP)
      else $error("auto increment missing");
   ignore_code_a: assert property (
      clk_en_in && cmd_write && wr_data_in[CMD_TYPE_MSB:CMD_TYPE_LSB] == TYPE_SPECIAL && !interrupt_set_in
      && (wr_data_in[INDEX_MSB:0] == 5'h00 || wr_data_in[3:2] == 2'h3)
      |=> $stable(interrupt_flag) && !manual_start_out && !manual_stop_out) else $error("reserved code acted");
   power_halt_a: assert property (
      clk_en_in && !power |=> !manual_active_out)
      else $error("integration survived power off");
endmodule

// file: design/light_sensor_pkg.sv
// Constants shared by the light sensor command and control logic
package light_sensor_pkg;
   // ***********************************************
   // Command byte layout
   // ***********************************************
   localparam int CMD_TYPE_MSB = 6;
   localparam int CMD_TYPE_LSB = 5;
   localparam int INDEX_MSB = 4;
   localparam int INDEX_W = 5;
   localparam logic [1:0] TYPE_REPEAT = 2'h0;
   localparam logic [1:0] TYPE_AUTO = 2'h1;
   localparam logic [1:0] TYPE_SPECIAL = 2'h3;
   localparam logic [4:0] SF_INT_CLEAR = 5'h01;
   localparam logic [4:0] SF_STOP = 5'h02;
   localparam logic [4:0] SF_START = 5'h03;
   localparam logic [4:0] INDEX_STEP = 5'h01;
   localparam logic [4:0] INDEX_RESET = 5'h00;
   localparam logic [1:0] TYPE_RESET = 2'h0;
   // ***********************************************
   // Register map
   // ***********************************************
   localparam logic [4:0] CTRL_ADDR = 5'h00;
   localparam logic [4:0] TIMER_LO_ADDR = 5'h18;
   localparam logic [4:0] TIMER_HI_ADDR = 5'h19;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam int POWER_BIT = 0;
   localparam int ENABLE_BIT = 1;
   localparam int VALID_BIT = 4;
   localparam int INTR_BIT = 5;
   localparam logic [7:0] MANUAL_TIMING = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   // ***********************************************
   // Manual timer resolution
   // ***********************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int TIMER_TICK_NS = 1000;
   localparam int TIMER_TICK_CYCLES = (TIMER_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TIMER_W = 16;
endpackage

// file: design/manual_integration_timer.sv
// Measures the length of a manual integration in timer ticks
`timescale 1ns/1ps
module manual_integration_timer
   import light_sensor_pkg::*;
#(
   parameter int TICK_CYCLES = TIMER_TICK_CYCLES,
   parameter int WIDTH = TIMER_W
) (
   input wire logic core_clk_in,
   input wire logic resetn_in,
   input wire logic clk_en_in,
   input wire logic start_in,
   input wire logic stop_in,
   input wire logic halt_in,
   output logic [WIDTH-1:0] duration_out
);
   logic [15:0] prescale;
   logic [WIDTH-1:0] count;
   logic running;

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         running <= 1'b0;
         prescale <= '0;
         count <= '0;
      end else if (clk_en_in) begin
         if (halt_in || stop_in) begin
            running <= 1'b0;
         end else if (start_in) begin
            running <= 1'b1;
            prescale <= '0;
            count <= '0;
         end else if (running) begin
            if (prescale == 16'(TICK_CYCLES - 1)) begin
               prescale <= '0;
               // Saturate rather than wrap
               if (count != '1) begin
                  count <= count + WIDTH'(1);
               end
            end else begin
               prescale <= prescale + 16'h0001;
            end
         end
      end
   end

   // Duration published only on a completed integration
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         duration_out <= '0;
      end else if (clk_en_in && stop_in && running && !halt_in) begin
         duration_out <= count;
      end
   end
endmodule

// file: test/light_host_model.sv
// Host model that writes command and data bytes to the sensor
`timescale 1ns/1ps
module light_host_model #(
   parameter int SETTLE_CYCLES = 20
) (
   input wire logic core_clk_in,
   output logic wr_valid_out,
   output logic wr_is_command_out,
   output logic [7:0] wr_data_out,
   output logic rd_strobe_out
);
   initial begin
      wr_valid_out = 1'b0;
      wr_is_command_out = 1'b0;
      wr_data_out = 8'h00;
      rd_strobe_out = 1'b0;
   end
   task automatic put_byte(input logic cmd, input logic [7:0] b);
      @(negedge core_clk_in);
      wr_valid_out = 1'b1;
      wr_is_command_out = cmd;
      wr_data_out = b;
      @(negedge core_clk_in);
      wr_valid_out = 1'b0;
      wr_data_out = ~b;
   endtask
   task automatic command(input logic [6:0] c);
      put_byte(1'b1, {1'b1, c});
   endtask
   task automatic data(input logic [7:0] b);
      put_byte(1'b0, b);
   endtask
   task automatic control(input logic [7:0] b);
      command(7'h00);
      data(b & 8'h33);
   endtask
   // Power first, settle, then enable
   task automatic power_up();
      control(8'h01);
      repeat (SETTLE_CYCLES) @(negedge core_clk_in);
      control(8'h03);
   endtask
   task automatic consume();
      @(negedge core_clk_in);
      rd_strobe_out = 1'b1;
      @(negedge core_clk_in);
      rd_strobe_out = 1'b0;
   endtask
endmodule

// file: test/light_sensor_command_control_tb.sv
// Self-checking bench for the light sensor command and control block
`timescale 1ns/1ps
module light_sensor_command_control_tb;
   import light_sensor_pkg::*;
   logic core_clk_in, resetn_in, wr_valid, wr_cmd, rd_strobe, cycle_done, int_set;
   logic [7:0] wr_data, ext_data, int_cycles, rdata, wdat;
   logic [4:0] idx, widx;
   logic reg_wr, power, adc_en, conv, m_start, m_stop, m_active, intr, clk_en;
   int fails = 0;
   int n_compared = 0;
   int n_start = 0;
   int n_stop = 0;
   int b;
   light_sensor_command_control #(.TICK_CYCLES(2)) i_dut (.core_clk_in(core_clk_in), .resetn_in(resetn_in),
      .clk_en_in(clk_en), .wr_valid_in(wr_valid), .wr_is_command_in(wr_cmd), .wr_data_in(wr_data),
      .rd_strobe_in(rd_strobe), .ext_read_data_in(ext_data), .integration_cycles_in(int_cycles),
      .adc_cycle_done_in(cycle_done), .interrupt_set_in(int_set), .read_data_out(rdata),
      .register_index_out(idx), .reg_write_out(reg_wr), .reg_write_index_out(widx), .reg_write_data_out(wdat),
      .power_out(power), .adc_enable_out(adc_en), .converting_out(conv), .manual_start_out(m_start),
      .manual_stop_out(m_stop), .manual_active_out(m_active), .interrupt_out(intr));
   light_host_model #(.SETTLE_CYCLES(20)) i_host (.core_clk_in(core_clk_in), .wr_valid_out(wr_valid),
      .wr_is_command_out(wr_cmd), .wr_data_out(wr_data), .rd_strobe_out(rd_strobe));
   initial begin
      core_clk_in = 1'b0;
      forever #5 core_clk_in = ~core_clk_in;
   end
   always @(posedge core_clk_in) begin
      n_start <= n_start + int'(m_start === 1'b1);
      n_stop <= n_stop + int'(m_stop === 1'b1);
   end
   // ***********************************************
   // Helpers
   // ***********************************************
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic rd(input logic [4:0] a);
      i_host.command({2'h0, a});
      repeat (2) @(negedge core_clk_in);
   endtask
   // One-cycle pulse on cycle done (1) or interrupt set (0)
   task automatic pulse_in(input logic done_not_intr);
      @(negedge core_clk_in);
      if (done_not_intr) begin
         cycle_done = 1'b1;
      end else begin
         int_set = 1'b1;
      end
      @(negedge core_clk_in);
      cycle_done = 1'b0;
      int_set = 1'b0;
   endtask
   task automatic conclude();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ***********************************************
   // Scenarios
   // ***********************************************
   task automatic t_reset();
      chk("power", 8'h00, {7'h00, power});
      chk("index", 8'h00, {3'h0, idx});
      chk("ctrl", CTRL_RESET, rdata);
   endtask
   task automatic t_power();
      i_host.control(8'h31);
      chk("power", 8'h01, {7'h00, power});
      @(negedge core_clk_in);
      chk("conv", 8'h00, {7'h00, conv});
      rd(CTRL_ADDR);
      chk("ctrl", 8'h01, rdata);
      i_host.power_up();
      chk("enable", 8'h01, {7'h00, adc_en});
      @(negedge core_clk_in);
      chk("conv", 8'h01, {7'h00, conv});
   endtask
   task automatic t_pointer();
      i_host.command(7'h25);
      chk("index", 8'h05, {3'h0, idx});
      i_host.data(8'h5A);
      chk("wr", 8'h01, {7'h00, reg_wr});
      chk("widx", 8'h05, {3'h0, widx});
      chk("wdat", 8'h5A, wdat);
      chk("index", 8'h06, {3'h0, idx});
      i_host.consume();
      chk("index", 8'h07, {3'h0, idx});
      i_host.command(7'h3F);
      i_host.consume();
      chk("index", 8'h00, {3'h0, idx});
      i_host.command(7'h0A);
      i_host.data(8'h11);
      chk("index", 8'h0A, {3'h0, idx});
      ext_data = 8'hC3;
      rd(5'h03);
      chk("ext", 8'hC3, rdata);
   endtask
   task automatic t_manual();
      int_cycles = 8'hFF;
      b = n_start;
      i_host.command(7'h63);
      repeat (4) @(negedge core_clk_in);
      chk("start", 8'h00, 8'(n_start - b));
      int_cycles = MANUAL_TIMING;
      i_host.command(7'h63);
      repeat (3) @(negedge core_clk_in);
      chk("start", 8'h01, 8'(n_start - b));
      chk("active", 8'h01, {7'h00, m_active});
      repeat (40) @(negedge core_clk_in);
      i_host.command(7'h62);
      repeat (3) @(negedge core_clk_in);
      chk("active", 8'h00, {7'h00, m_active});
      chk("stop", 8'h01, n_stop[7:0]);
      rd(TIMER_LO_ADDR);
      n_compared++;
      if (rdata < 8'h12 || rdata > 8'h1A) begin
         fails++;
         $display("[ERR] timer expected 12..1A seen %h", rdata);
      end
      rd(TIMER_HI_ADDR);
      chk("timer_hi", 8'h00, rdata);
      rd(CTRL_ADDR);
      chk("ctrl", 8'h13, rdata);
   endtask
   task automatic t_interrupt();
      pulse_in(1'b0);
      chk("intr", 8'h01, {7'h00, intr});
      rd(CTRL_ADDR);
      chk("ctrl", 8'h33, rdata);
      i_host.command(7'h60);
      i_host.command(7'h6C);
      i_host.command(7'h7F);
      @(negedge core_clk_in);
      chk("intr", 8'h01, {7'h00, intr});
      chk("index", 8'h00, {3'h0, idx});
      i_host.command(7'h61);
      @(negedge core_clk_in);
      chk("intr", 8'h00, {7'h00, intr});
   endtask
   task automatic t_off();
      i_host.command(7'h63);
      repeat (4) @(negedge core_clk_in);
      i_host.control(8'h00);
      @(negedge core_clk_in);
      chk("active", 8'h00, {7'h00, m_active});
      chk("conv", 8'h00, {7'h00, conv});
      i_host.power_up();
      pulse_in(1'b1);
      rd(CTRL_ADDR);
      chk("ctrl", 8'h13, rdata);
   endtask
   // Frozen clock enable drops commands and events, then a mid-run reset
   task automatic t_freeze();
      @(negedge core_clk_in);
      clk_en = 1'b0;
      i_host.command(7'h25);
      pulse_in(1'b0);
      chk("index", 8'h00, {3'h0, idx});
      chk("intr", 8'h00, {7'h00, intr});
      chk("power", 8'h01, {7'h00, power});
      clk_en = 1'b1;
      rd(CTRL_ADDR);
      chk("ctrl", 8'h13, rdata);
      resetn_in = 1'b0;
      @(negedge core_clk_in);
      resetn_in = 1'b1;
      @(negedge core_clk_in);
      chk("power", 8'h00, {7'h00, power});
      chk("ctrl", CTRL_RESET, rdata);
   endtask
   initial begin
      resetn_in = 1'b0;
      clk_en = 1'b1;
      cycle_done = 1'b0;
      int_set = 1'b0;
      ext_data = 8'h3C;
      int_cycles = MANUAL_TIMING;
      repeat (6) @(negedge core_clk_in);
      resetn_in = 1'b1;
      @(negedge core_clk_in);
      t_reset();
      t_power();
      t_pointer();
      t_manual();
      t_interrupt();
      t_off();
      t_freeze();
      conclude();
   end
   initial begin
      #200us;
      fails++;
      conclude();
   end
endmodule
